// [hdl/plcc_pkg.sv]
package plcc_pkg;
	localparam int LANES = 4;
	localparam logic [11:0] OFS_CFG = 12'h534;
	localparam logic [11:0] OFS_STS = 12'h540;
	localparam logic [31:0] CFG_RESET = 32'h2020_0000;
	localparam logic [31:0] CFG_WMASK = 32'h7fff_010f;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;
	localparam int STS_FTS_ACTIVE = 0;
	localparam int STS_SKIP_DET = 1;
	localparam int STS_RX_MASK = 2;
	localparam int STS_TX_HOLD = 3;
	localparam int STS_TIMEOUT = 4;
	localparam int STS_FORCE_EN = 5;
	localparam int STS_LANE_LSB = 8;
	localparam int CLK_PERIOD_PS = 50000;
	localparam int UI_GEN1_PS = 400;
	localparam int UI_GEN2_PS = 200;
	localparam int SYM_UI = 10;
	localparam int FTS_SYMS = 4;
	localparam int NFTS_TO_MULT = 40;
	localparam int PS_PER_NS = 1000;
	localparam int RX_IDLE_NS0 = 20;
	localparam int RX_IDLE_NS1 = 40;
	localparam int RX_IDLE_NS2 = 80;
	localparam int RX_IDLE_NS3 = 160;
	localparam int TX_IDLE_NS0 = 20;
	localparam int TX_IDLE_NS1 = 100;
	localparam int TX_IDLE_NS2 = 500;
	localparam int TX_IDLE_NS3 = 1000;
	localparam int SKIP_FULL_SYMS = 3;
	localparam int SKIP_COMP_SYMS = 1;

	typedef logic [7:0] plcc_cnt_t;

	typedef struct packed {
		logic rsv31;
		logic tx_uncompressed_skip_sel;
		logic [1:0] l0s_rx_skip_detect_delay;
		logic [1:0] l0s_rx_idle_min_time;
		logic [1:0] tx_idle_min_time;
		logic [7:0] fts_exit_timeout_extra;
		logic [6:0] rsv15_9;
		logic lane_invert_force_en;
		logic [3:0] rsv7_4;
		logic [3:0] lane_invert_force_bits;
	} plcc_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] ofs;
	} plcc_req_t;

	typedef struct packed {
		logic valid;
		logic compressed;
	} plcc_skip_t;

	function automatic plcc_cnt_t ps_up(int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return plcc_cnt_t'((c < 1) ? 1 : c);
	endfunction

	function automatic plcc_cnt_t rx_idle_cycles(logic [1:0] sel);
		unique case (sel)
			2'h0: return ps_up(RX_IDLE_NS0 * PS_PER_NS);
			2'h1: return ps_up(RX_IDLE_NS1 * PS_PER_NS);
			2'h2: return ps_up(RX_IDLE_NS2 * PS_PER_NS);
			2'h3: return ps_up(RX_IDLE_NS3 * PS_PER_NS);
		endcase
	endfunction

	function automatic plcc_cnt_t tx_idle_cycles(logic [1:0] sel);
		unique case (sel)
			2'h0: return ps_up(TX_IDLE_NS0 * PS_PER_NS);
			2'h1: return ps_up(TX_IDLE_NS1 * PS_PER_NS);
			2'h2: return ps_up(TX_IDLE_NS2 * PS_PER_NS);
			2'h3: return ps_up(TX_IDLE_NS3 * PS_PER_NS);
		endcase
	endfunction

	function automatic plcc_cnt_t skip_wait_cycles(logic [1:0] sel,
		logic [7:0] nfts, logic gen2);
		int units;
		int ui;
		ui = gen2 ? UI_GEN2_PS : UI_GEN1_PS;
		unique case (sel)
			2'h0: units = 0;
			2'h1: units = int'(nfts >> 2);
			2'h2: units = int'(nfts >> 1);
			2'h3: units = int'(nfts);
		endcase
		if (units == 0)
			return '0;
		return ps_up(units * FTS_SYMS * SYM_UI * ui);
	endfunction

	function automatic plcc_cnt_t fts_timeout_cycles(logic [7:0] nfts,
		logic [7:0] extra, logic gen2);
		int ps;
		int c;
		ps = NFTS_TO_MULT * (int'(nfts) + int'(extra))
			* (gen2 ? UI_GEN2_PS : UI_GEN1_PS);
		c = ps / CLK_PERIOD_PS;
		return plcc_cnt_t'((c < 1) ? 1 : c);
	endfunction
endpackage

// [hdl/plcc_dwell_timer.sv]
`timescale 1ns/10ps
module plcc_dwell_timer (
	input wire logic i_clk, // Clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_start, // Load dwell length
	input wire logic i_cancel, // Abort dwell
	input wire plcc_pkg::plcc_cnt_t i_cycles, // Dwell length
	output logic o_busy, // Dwell running
	output logic o_done // Last dwell cycle
);
	plcc_pkg::plcc_cnt_t cnt_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else if (i_cancel) begin
			cnt_q <= '0;
		end else if (i_start) begin
			cnt_q <= i_cycles;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	assign o_busy = (cnt_q != '0);
	assign o_done = (cnt_q == 8'h01) && !i_start && !i_cancel;
endmodule

// [hdl/plcc_skip_expander.sv]
`timescale 1ns/10ps
module plcc_skip_expander (
	input wire logic i_clk, // Clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_skip_req, // Skip set due
	input wire logic i_full_sel, // Send full sets
	output plcc_pkg::plcc_skip_t o_to_buf, // Set handed to buffer
	output logic o_busy, // Set being emitted
	output logic o_com_sym, // Comma symbol out
	output logic o_skp_sym, // Skip symbol out
	output logic o_inserted // Skip symbol added by buffer
);
	logic [2:0] left_q;
	logic [2:0] given_q;
	logic start;

	assign start = i_skip_req && !o_busy;
	assign o_busy = o_to_buf.valid || (left_q != '0);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_to_buf <= '0;
		end else begin
			o_to_buf.valid <= start;
			o_to_buf.compressed <= start ? !i_full_sel : 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			left_q <= '0;
			given_q <= '0;
		end else if (o_to_buf.valid) begin
			// Buffer always emits a full set
			left_q <= 3'(plcc_pkg::SKIP_FULL_SYMS);
			given_q <= o_to_buf.compressed ?
				3'(plcc_pkg::SKIP_COMP_SYMS) :
				3'(plcc_pkg::SKIP_FULL_SYMS);
		end else if (left_q != '0) begin
			left_q <= left_q - 3'h1;
			if (given_q != '0) begin
				given_q <= given_q - 3'h1;
			end
		end
	end

	assign o_com_sym = o_to_buf.valid;
	assign o_skp_sym = (left_q != '0);
	assign o_inserted = (left_q != '0) && (given_q == '0);
endmodule

// [hdl/plcc_link_cfg.sv]
`timescale 1ns/10ps
module plcc_link_cfg (
	input wire logic i_clk, // 20 MHz clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_hsel, // AHB select
	input wire logic [31:0] i_haddr, // AHB address
	input wire logic [1:0] i_htrans, // AHB transfer type
	input wire logic i_hwrite, // AHB write
	input wire logic [2:0] i_hsize, // AHB size
	input wire logic [31:0] i_hwdata, // AHB write data
	input wire logic i_hready, // AHB bus ready
	output logic o_hreadyout, // AHB slave ready
	output logic o_hresp, // AHB response
	output logic [31:0] o_hrdata, // AHB read data
	input wire logic [7:0] i_nfts, // Advertised N_FTS
	input wire logic i_gen2, // Link at Gen2 rate
	input wire logic i_tx_skip_req, // Skip set due
	input wire logic i_rx_l0s_entry, // Rx L0s entry pulse
	input wire logic i_rx_fts_enter, // Rx L0s FTS entry pulse
	input wire logic i_rx_fts_exit, // Rx L0s FTS left pulse
	input wire logic i_tx_idle_entry, // Tx L0s or L1 entry pulse
	input wire logic i_detect_entry, // Detect entry pulse
	input wire logic [3:0] i_auto_lane_invert, // Automatic polarity
	output plcc_pkg::plcc_skip_t o_skip_to_buf, // Skip set to buffer
	output logic o_eb_com_sym, // Buffer comma out
	output logic o_eb_skp_sym, // Buffer skip symbol out
	output logic o_eb_inserted, // Buffer added skip
	output logic o_rx_idle_exit_mask, // Ignore idle exit
	output logic o_rx_l0s_entry_done, // Rx entry dwell ends
	output logic o_rx_skip_detect_en, // Skip detection on
	output logic o_fts_timeout, // N_FTS timeout pulse
	output logic o_tx_idle_hold, // Hold electrical idle
	output logic o_tx_idle_done, // Tx idle dwell ends
	output logic [3:0] o_lane_invert // Receive polarity invert
);
	plcc_pkg::plcc_cfg_t cfg_q;
	plcc_pkg::plcc_req_t req_q;
	logic force_en_q;
	logic [3:0] force_bits_q;
	logic fts_active_q;
	logic timeout_q;
	logic [31:0] sts;
	logic addr_ok;
	logic wr_cfg;
	logic wr_sts;
	logic skip_busy;
	logic to_done;
	logic skip_exp_busy;
	plcc_pkg::plcc_cnt_t skip_cyc;
	plcc_pkg::plcc_cnt_t to_cyc;

	// Bus slave: zero wait state, always OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp = plcc_pkg::HRESP_OKAY;
	assign addr_ok = i_hsel && i_hready &&
		(i_htrans == plcc_pkg::HTRANS_NONSEQ ||
		i_htrans == plcc_pkg::HTRANS_SEQ);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_q <= '0;
		end else if (i_hready) begin
			req_q.wr <= addr_ok && i_hwrite;
			req_q.rd <= addr_ok && !i_hwrite;
			req_q.ofs <= {i_haddr[11:2], 2'h0};
		end
	end

	assign wr_cfg = req_q.wr && (req_q.ofs == plcc_pkg::OFS_CFG);
	assign wr_sts = req_q.wr && (req_q.ofs == plcc_pkg::OFS_STS);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_q <= plcc_pkg::plcc_cfg_t'(plcc_pkg::CFG_RESET);
		end else if (wr_cfg) begin
			cfg_q <= plcc_pkg::plcc_cfg_t'(i_hwdata &
				plcc_pkg::CFG_WMASK);
		end
	end

	always_comb begin
		sts = '0;
		sts[plcc_pkg::STS_FTS_ACTIVE] = fts_active_q;
		sts[plcc_pkg::STS_SKIP_DET] = o_rx_skip_detect_en;
		sts[plcc_pkg::STS_RX_MASK] = o_rx_idle_exit_mask;
		sts[plcc_pkg::STS_TX_HOLD] = o_tx_idle_hold;
		sts[plcc_pkg::STS_TIMEOUT] = timeout_q;
		sts[plcc_pkg::STS_FORCE_EN] = force_en_q;
		sts[plcc_pkg::STS_LANE_LSB +: plcc_pkg::LANES] = o_lane_invert;
	end

	always_comb begin
		o_hrdata = '0;
		if (req_q.rd && req_q.ofs == plcc_pkg::OFS_CFG) begin
			o_hrdata = 32'(cfg_q);
		end else if (req_q.rd && req_q.ofs == plcc_pkg::OFS_STS) begin
			o_hrdata = sts;
		end
	end

	// Sticky timeout flag, write one to clear, a new event wins
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			timeout_q <= 1'b0;
		end else if (to_done) begin
			timeout_q <= 1'b1;
		end else if (wr_sts && i_hwdata[plcc_pkg::STS_TIMEOUT]) begin
			timeout_q <= 1'b0;
		end
	end

	plcc_skip_expander u_skip (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_skip_req(i_tx_skip_req),
		.i_full_sel(cfg_q.tx_uncompressed_skip_sel),
		.o_to_buf(o_skip_to_buf),
		.o_busy(skip_exp_busy),
		.o_com_sym(o_eb_com_sym),
		.o_skp_sym(o_eb_skp_sym),
		.o_inserted(o_eb_inserted)
	);

	plcc_dwell_timer u_rx_idle (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_start(i_rx_l0s_entry),
		.i_cancel(1'b0),
		.i_cycles(plcc_pkg::rx_idle_cycles(
			cfg_q.l0s_rx_idle_min_time)),
		.o_busy(o_rx_idle_exit_mask),
		.o_done(o_rx_l0s_entry_done)
	);

	plcc_dwell_timer u_tx_idle (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_start(i_tx_idle_entry),
		.i_cancel(1'b0),
		.i_cycles(plcc_pkg::tx_idle_cycles(
			cfg_q.tx_idle_min_time)),
		.o_busy(o_tx_idle_hold),
		.o_done(o_tx_idle_done)
	);

	assign skip_cyc = plcc_pkg::skip_wait_cycles(
		cfg_q.l0s_rx_skip_detect_delay, i_nfts, i_gen2);
	assign to_cyc = plcc_pkg::fts_timeout_cycles(i_nfts,
		cfg_q.fts_exit_timeout_extra, i_gen2);

	plcc_dwell_timer u_skip_wait (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_start(i_rx_fts_enter),
		.i_cancel(i_rx_fts_exit),
		.i_cycles(skip_cyc),
		.o_busy(skip_busy),
		.o_done()
	);

	plcc_dwell_timer u_fts_to (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_start(i_rx_fts_enter),
		.i_cancel(i_rx_fts_exit),
		.i_cycles(to_cyc),
		.o_busy(),
		.o_done(to_done)
	);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fts_active_q <= 1'b0;
		end else if (i_rx_fts_enter) begin
			fts_active_q <= 1'b1;
		end else if (i_rx_fts_exit || to_done) begin
			fts_active_q <= 1'b0;
		end
	end

	assign o_rx_skip_detect_en = fts_active_q && !skip_busy;
	assign o_fts_timeout = to_done;

	// Force settings are sampled only on entry to Detect
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			force_en_q <= 1'b0;
			force_bits_q <= '0;
		end else if (i_detect_entry) begin
			force_en_q <= cfg_q.lane_invert_force_en;
			force_bits_q <= cfg_q.lane_invert_force_bits;
		end
	end

	for (genvar n = 0; n < plcc_pkg::LANES; n++) begin : g_lane
		assign o_lane_invert[n] = force_en_q ? force_bits_q[n] :
			i_auto_lane_invert[n];
	end

	// Helper: cycles since FTS entry
	plcc_pkg::plcc_cnt_t to_elapsed_q;
	plcc_pkg::plcc_cnt_t to_len_q;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			to_elapsed_q <= '0;
			to_len_q <= '0;
		end else if (i_rx_fts_enter) begin
			to_elapsed_q <= 8'h01;
			to_len_q <= to_cyc;
		end else if (to_elapsed_q != 8'hff) begin
			to_elapsed_q <= to_elapsed_q + 8'h01;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_skip_compressed: assert property (
		o_skip_to_buf.valid |->
		o_skip_to_buf.compressed == !$past(cfg_q.tx_uncompressed_skip_sel))
		else $error("skip set compression does not follow full-skip bit");
	a_skip_expand: assert property (
		(i_tx_skip_req && !skip_exp_busy) |=>
		o_eb_com_sym ##1 o_eb_skp_sym [*3] ##1 !o_eb_skp_sym)
		else $error("skip set not expanded to a full set");
	a_skip_wait_held: assert property (
		(i_rx_fts_enter && !i_rx_fts_exit && skip_cyc != '0) |=>
		!o_rx_skip_detect_en)
		else $error("skip detection started before its wait");
	a_skip_no_wait: assert property (
		(i_rx_fts_enter && !i_rx_fts_exit &&
		cfg_q.l0s_rx_skip_detect_delay == 2'h0) |=> o_rx_skip_detect_en)
		else $error("zero skip delay did not start detection at once");
	a_rx_mask_len: assert property (
		(i_rx_l0s_entry && cfg_q.l0s_rx_idle_min_time == 2'h3) |=>
		o_rx_idle_exit_mask [*4])
		else $error("rx idle exit mask shorter than 160 ns");
	a_tx_hold_len: assert property (
		(i_tx_idle_entry && cfg_q.tx_idle_min_time == 2'h2) |=>
		o_tx_idle_hold [*8] ##2 (o_tx_idle_hold || $past(i_tx_idle_entry)
		|| !$past(o_tx_idle_hold)))
		else $error("tx idle hold shorter than 500 ns");
	a_timeout_len: assert property (
		o_fts_timeout |-> to_elapsed_q == to_len_q)
		else $error("N_FTS timeout fired at the wrong cycle");
	a_cfg_reset: assert property (
		$rose(i_rstn) |-> (cfg_q.fts_exit_timeout_extra == 8'h20 &&
		cfg_q.l0s_rx_skip_detect_delay == 2'h2))
		else $error("configuration reset value wrong");
	a_force_apply: assert property (
		i_detect_entry |=> force_bits_q == $past(cfg_q.lane_invert_force_bits)
		&& force_en_q == $past(cfg_q.lane_invert_force_en))
		else $error("force settings not taken at Detect");
	a_force_hold: assert property (
		!$past(i_detect_entry) |-> ($stable(force_en_q) &&
		$stable(force_bits_q)))
		else $error("force settings changed outside Detect");
	a_force_lanes: assert property (
		force_en_q |-> o_lane_invert == force_bits_q)
		else $error("lane polarity ignores force bits");
	a_rsv_zero: assert property (
		(req_q.rd && req_q.ofs == plcc_pkg::OFS_CFG) |->
		(o_hrdata & ~plcc_pkg::CFG_WMASK) == '0)
		else $error("reserved bits read non-zero");

	c_timeout: cover property (o_fts_timeout);
	c_compressed: cover property (o_skip_to_buf.valid &&
		o_skip_to_buf.compressed ##2 o_eb_inserted);
	c_force: cover property (i_detect_entry ##1 force_en_q);
	c_tx_hold: cover property (i_tx_idle_entry ##1 o_tx_idle_hold [*8]);
endmodule

// [verification/plcc_ltssm_model.sv]
`timescale 1ns/10ps
module plcc_ltssm_model (
	input wire logic i_clk, // Clock
	output logic [7:0] o_nfts, // Advertised N_FTS
	output logic o_gen2, // Gen2 rate
	output logic [3:0] o_auto_inv, // Automatic polarity
	output logic [5:0] o_ev // Event pulses
);
	// Event bits: skip, rx entry, fts enter, fts exit, tx entry, detect
	initial begin
		o_nfts = 8'h50;
		o_gen2 = 1'b0;
		o_auto_inv = 4'h5;
		o_ev = '0;
	end

	task automatic pulse(input int k);
		@(posedge i_clk);
		o_ev[k] <= 1'b1;
		@(posedge i_clk);
		o_ev[k] <= 1'b0;
	endtask

	task automatic set_link(input logic [7:0] n, input logic g,
		input logic [3:0] inv);
		@(posedge i_clk);
		o_nfts <= n;
		o_gen2 <= g;
		o_auto_inv <= inv;
	endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	plcc_pkg::plcc_skip_t skip;
	logic com, skp, ins, rxm, rxd, det, tmo, txh, txd;
	logic [3:0] inv, auto_inv;
	logic [7:0] nfts;
	logic gen2;
	logic [5:0] ev;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	int k, k2;
	logic [31:0] r;
	int rx_ns[4] = '{20, 40, 80, 160};
	int tx_ns[4] = '{20, 100, 500, 1000};

	always #25 i_clk = ~i_clk;

	plcc_ltssm_model partner (
		.i_clk(i_clk),
		.o_nfts(nfts),
		.o_gen2(gen2),
		.o_auto_inv(auto_inv),
		.o_ev(ev)
	);

	plcc_link_cfg dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_nfts(nfts), .i_gen2(gen2), .i_tx_skip_req(ev[0]),
		.i_rx_l0s_entry(ev[1]), .i_rx_fts_enter(ev[2]),
		.i_rx_fts_exit(ev[3]), .i_tx_idle_entry(ev[4]),
		.i_detect_entry(ev[5]), .i_auto_lane_invert(auto_inv),
		.o_skip_to_buf(skip), .o_eb_com_sym(com), .o_eb_skp_sym(skp),
		.o_eb_inserted(ins), .o_rx_idle_exit_mask(rxm),
		.o_rx_l0s_entry_done(rxd), .o_rx_skip_detect_en(det),
		.o_fts_timeout(tmo), .o_tx_idle_hold(txh), .o_tx_idle_done(txd),
		.o_lane_invert(inv)
	);

	// Read data captured at the data phase edge
	always @(posedge i_clk) begin
		rd_q <= hrdata;
		cyc++;
		if (cyc >= 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got,
				exp);
		end
	endtask

	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= plcc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(posedge i_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge i_clk); while (hreadyout !== 1'b1);
		#1;
		q = rd_q;
		check(32'(hresp), 32'(plcc_pkg::HRESP_OKAY), "resp");
	endtask

	task automatic wr(input logic [31:0] d);
		bus(1'b1, plcc_pkg::OFS_CFG, d, r);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, r);
		check(r, e, "read");
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return rxm;
			1: return txh;
			2: return det;
			4: return rxd;
			5: return txd;
			default: return tmo;
		endcase
	endfunction

	// Edges after the launching edge until the output shows lvl
	task automatic meas(input int w, input logic lvl, output int n);
		n = 0;
		#1;
		while (sig(w) !== lvl && n < 300) begin
			@(posedge i_clk);
			#1;
			n++;
		end
	endtask

	function automatic int up(input int ps);
		int c;
		c = (ps + plcc_pkg::CLK_PERIOD_PS - 1) / plcc_pkg::CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int ui(input logic g);
		return g ? 200 : 400;
	endfunction

	function automatic int wait_exp(input int s, input int n, input logic g);
		int u;
		u = (s == 0) ? 0 : (s == 1) ? n / 4 : (s == 2) ? n / 2 : n;
		return (u == 0) ? 0 : up(u * 4 * 10 * ui(g));
	endfunction

	function automatic int to_exp(input int n, input int e, input logic g);
		int c;
		c = 40 * (n + e) * ui(g) / plcc_pkg::CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	initial begin
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		rdchk(plcc_pkg::OFS_CFG, 32'h2020_0000);
		rdchk(12'h7fc, 32'h0);
		wr(32'hffff_ffff);
		rdchk(plcc_pkg::OFS_CFG, 32'h7fff_010f);
		check(32'(inv), 32'h5, "inv held");
		for (int f = 0; f < 2; f++) begin
			wr(32'h2020_0000 | (f << 30));
			partner.pulse(0);
			#1;
			check(32'(skip), {30'h0, 1'b1, f == 0}, "skip set");
			check(32'(com), 32'h1, "comma");
			for (int i = 1; i < 4; i++) begin
				@(posedge i_clk);
				#1;
				check(32'(skp), 32'h1, "skip sym");
				check(32'(ins), 32'(f == 0 && i >= 2), "insert");
			end
		end
		for (int s = 0; s < 4; s++) begin
			wr(32'h2020_0000 | (s << 26) | (s << 24));
			partner.pulse(1);
			meas(4, 1'b1, k2);
			check(k2 + 1, up(rx_ns[s] * 1000), "rx done");
			meas(0, 1'b0, k);
			check(k + k2, up(rx_ns[s] * 1000), "rx dwell");
			partner.pulse(4);
			meas(5, 1'b1, k2);
			check(k2 + 1, up(tx_ns[s] * 1000), "tx done");
			meas(1, 1'b0, k);
			check(k + k2, up(tx_ns[s] * 1000), "tx dwell");
		end
		for (int s = 0; s < 4; s++) begin
			wr(32'h0020_0000 | (s << 28));
			partner.pulse(2);
			meas(2, 1'b1, k);
			check(k, wait_exp(s, 80, 1'b0), "skip wait");
			meas(3, 1'b1, k2);
			// Pulse stands in the last counted cycle
			check(k + k2 + 1, to_exp(80, 32, 1'b0), "timeout");
			partner.pulse(3);
		end
		// Sticky timeout set, auto polarity shown, then cleared
		rdchk(plcc_pkg::OFS_STS, 32'h0000_0510);
		bus(1'b1, plcc_pkg::OFS_STS, 32'h0000_0010, r);
		rdchk(plcc_pkg::OFS_STS, 32'h0000_0500);
		partner.set_link(8'h64, 1'b1, 4'h5);
		wr(32'h0003_0000);
		partner.pulse(2);
		meas(2, 1'b1, k);
		meas(3, 1'b1, k2);
		check(k + k2 + 1, to_exp(100, 3, 1'b1), "gen2 timeout");
		partner.pulse(3);
		wr(32'h2020_010a);
		check(32'(inv), 32'h5, "inv before");
		partner.pulse(5);
		#1;
		check(32'(inv), 32'ha, "inv forced");
		wr(32'h2020_0000);
		partner.set_link(8'h50, 1'b0, 4'h3);
		check(32'(inv), 32'ha, "inv kept");
		partner.pulse(5);
		#1;
		check(32'(inv), 32'h3, "inv auto");
		tally_and_finish();
	end
endmodule
